// *** dv/amp_level_model.sv ***
// amp_level_model: behavioural stand-in for the two amplifier outputs.
// assumes the trim codes of the switch controls; each output flips at a set code.
`default_nettype none
module amp_level_model
   import amp_switch_pkg::*;
#(
   parameter logic [4:0] TRIP1 = 5'h12,  // residual offset of amp1, arbitrary
   parameter logic [4:0] TRIP2 = 5'h0B   // residual offset of amp2, arbitrary
) (
   input  wire amp_ctl_t i_amp1,
   input  wire amp_ctl_t i_amp2,
   output logic          o_lvl1,
   output logic          o_lvl2
);
   timeunit 1ns;
   timeprecision 1ps;
   // the level moves a few ns after the trim, unrelated to the clock edge
   assign #3 o_lvl1 = (i_amp1.trim_code >= TRIP1);
   assign #3 o_lvl2 = (i_amp2.trim_code >= TRIP2);
endmodule
`default_nettype wire

// *** dv/amp_switch_ctrl_bench.sv ***
// amp_switch_ctrl_bench: register and switch-decode tests of both variants.
// assumes the package offsets and power-on values; one 50 MHz clock.
`default_nettype none
module amp_switch_ctrl_bench
   import amp_switch_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [4:0] TRIP1 = 5'h12;
   localparam logic [4:0] TRIP2 = 5'h0B;
   logic       mclk = 1'b0;
   logic       sys_rst;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic       wr;
   logic       rd;
   logic [7:0] rdata;
   logic [7:0] rdata_lite;
   logic       lvl1;
   logic       lvl2;
   amp_ctl_t   amp1;
   amp_ctl_t   amp2;
   amp_ctl_t   lite1;
   gain_ctl_t  gain;
   int         err_total = 0;
   int         tests_run = 0;

   always #10 mclk = ~mclk;

   amp_switch_ctrl dut (.i_mclk(mclk), .i_sys_rst(sys_rst), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_amp1_out_raw(lvl1), .i_amp2_out_raw(lvl2),
      .o_amp1(amp1), .o_amp2(amp2), .o_gain(gain));
   // reduced variant rides on the same bus and levels
   amp_switch_ctrl #(.CAL_PRESENT(1'b0)) dut_lite (.i_mclk(mclk), .i_sys_rst(sys_rst),
      .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata_lite),
      .i_amp1_out_raw(lvl1), .i_amp2_out_raw(lvl2), .o_amp1(lite1), .o_amp2(), .o_gain());
   amp_level_model #(.TRIP1(TRIP1), .TRIP2(TRIP2)) model (.i_amp1(amp1), .i_amp2(amp2),
      .o_lvl1(lvl1), .o_lvl2(lvl2));

   // field packs keep the compares short
   function automatic amp_ctl_t pick(input int i);
      return i ? amp2 : amp1;
   endfunction
   function automatic logic [7:0] taps(input amp_ctl_t c);
      return {5'h0, c.low_tap_switch, c.mid_tap_switch, c.high_tap_switch};
   endfunction
   function automatic logic [7:0] sw(input amp_ctl_t c);
      return {1'b0, c.comparator_switch, c.self_feedback, c.pos_pin_connect,
              c.neg_pin_connect, c.output_drive_en, c.enable, c.out_pin_switch};
   endfunction
   function automatic logic [7:0] cal(input amp_ctl_t c);
      return {c.cal_neg_input_switch, c.cal_pos_input_switch, c.cal_short_switch, c.trim_code};
   endfunction
   function automatic logic [7:0] gx();
      return {2'h0, gain.amp1_to_amp2_neg, gain.amp1_to_amp2_pos, gain.gain_path_enable,
              gain.gain_code};
   endfunction

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   // extra edges let the switch outputs and the synchronised level settle
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge mclk);
      wr <= 1'b0;
      repeat (3) @(posedge mclk);
      #1;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      rd <= 1'b1;
      addr <= a;
      @(posedge mclk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask
   task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      rd_reg(a, d);
      chk(what, e, d);
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // watchdog: the tests take some 680 cycles
   initial begin
      #200000;
      err_total++;
      stop_test();
   end

   initial begin
      logic [7:0] d;
      logic [7:0] t;
      logic [7:0] p;
      amp_ctl_t   c;
      int         found;
      sys_rst = 1'b1;
      addr = 8'h00;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      repeat (4) @(posedge mclk);
      sys_rst <= 1'b0;
      rchk("amp1 trim", OFS_AMP1_TRIM, TRIM_RST);
      rchk("amp1 path", OFS_AMP1_PATH, PATH_RST);
      rchk("amp2 trim", OFS_AMP2_TRIM, 8'h90);
      rchk("amp2 path", OFS_AMP2_PATH, PATH_RST);
      rchk("gain reg", OFS_AMP2_GAIN, GAIN_RST);
      rchk("unmapped", 8'h05, 8'h00);
      @(posedge mclk);
      #1 chk("rdata idle", 8'h00, rdata);
      // per amplifier: trim/mode register, then path decode
      for (int i = 0; i < 2; i++) begin
         t = i ? OFS_AMP2_TRIM : OFS_AMP1_TRIM;
         p = i ? OFS_AMP2_PATH : OFS_AMP1_PATH;
         wr_reg(t, 8'h80);
         rchk("trim ro", t, 8'h00);
         wr_reg(t, 8'hFF);
         rchk("trim rw", t, 8'hFF);
         chk("lite trim", 8'h80, rdata_lite);
         chk("lite cal", 8'h00, cal(lite1));
         chk("cal pos ref", 8'h7F, cal(pick(i)));
         wr_reg(t, 8'h45);
         chk("cal neg ref", 8'hA5, cal(pick(i)));
         wr_reg(t, 8'h25);
         chk("cal normal", 8'hC5, cal(pick(i)));
         for (int s = 0; s < 4; s++) begin
            wr_reg(p, 8'h87 | 8'(s << 4));
            chk("taps", (s == 0) ? 8'h00 : 8'(1 << (s - 1)), taps(pick(i)));
            wr_reg(p, 8'h8F | 8'(s << 4));
            chk("taps forced", 8'h00, taps(pick(i)));
         end
         wr_reg(p, 8'h4E);
         rchk("path rw", p, 8'h4E);
         c = pick(i);
         chk("path off", 8'h24, sw(c));
         chk("pins free", 8'h01, {7'h0, c.pins_gpio});
         wr_reg(p, 8'hCF);
         chk("path on", 8'h7F, sw(pick(i)));
      end
      // gain and crosslink register
      wr_reg(OFS_AMP2_GAIN, 8'hFF);
      rchk("gain rw", OFS_AMP2_GAIN, 8'hCF);
      for (int g = 0; g < 8; g++) begin
         wr_reg(OFS_AMP2_GAIN, 8'h88 | 8'(g));
         chk("gain ctl", 8'h28 | 8'(g), gx());
         chk("gain value", (g == 0) ? 8'h01 : 8'(8 * g), {2'h0, gain.gain_value});
      end
      wr_reg(OFS_AMP2_GAIN, 8'h40);
      chk("link pos", 8'h10, gx());
      // offset calibration: step the trim through all 32 codes and note the first where the output level flips
      for (int i = 0; i < 2; i++) begin
         t = i ? OFS_AMP2_TRIM : OFS_AMP1_TRIM;
         found = 32;
         for (int k = 0; k < 32; k++) begin
            wr_reg(t, 8'h40 | 8'(k));
            rd_reg(t, d);
            if (found == 32 && d[7] === 1'b1)
               found = k;
         end
         wr_reg(t, 8'h10);
         chk("trip code", i ? 8'(TRIP2) : 8'(TRIP1), 8'(found));
      end
      stop_test();
   end
endmodule
`default_nettype wire

// *** verilog/amp_switch_ctrl.sv ***
// amp_switch_ctrl: five control registers for two op-amps and the
// decode that turns them into analog switch and trim controls.
// assumes strobes synchronous to i_mclk and raw comparator-level amp outputs.
//
// Functional notes
// R1 - trim register bit7 reads amp output, read-only
// R2 - bit6 selects offset cancellation mode
// R3 - bit5 picks cancellation reference input
// R4 - bits4:0 trim code, resets to 10h
// R5 - path bit7 closes comparator routing switch
// R6 - path bit6 closes self feedback path
// R7 - source field selects none/high/mid/low tap
// R8 - pos pin connect forces source to none
// R9 - bits3/2 connect pins, reset to one
// R10 - bit1 enables output driver, resets zero
// R11 - enable clear opens output pin switch
// R12 - second path register mirrors first layout
// R13 - gain bit7 links amp1 to amp2 inverting
// R14 - gain bit6 links amp1 to amp2 noninverting
// R15 - gain bit3 enables gain path
// R16 - gain code zero unity, else eight times code
// R17 - cancel mode closes short and one input
// R18 - software steps trim until output toggles
// R19 - gain bits5:4 read zero, ignore writes
// R20 - reduced variant keeps only output bit
// R21 - disabled amp returns all pins to gpio
// R22 - amp outputs pass two-flop synchroniser
// R23 - writes load on strobe, reset restores
`default_nettype none
module amp_switch_ctrl
   import amp_switch_pkg::*;
#(
   parameter bit CAL_PRESENT = 1'b1   // 0 builds the reduced variant
) (
   input  wire logic       i_mclk,
   input  wire logic       i_sys_rst,
   input  wire logic [7:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   output logic      [7:0] o_rdata,
   input  wire logic       i_amp1_out_raw,
   input  wire logic       i_amp2_out_raw,
   output amp_ctl_t        o_amp1,
   output amp_ctl_t        o_amp2,
   output gain_ctl_t       o_gain
);

   logic [7:0] amp1_trim_reg;
   logic [7:0] amp1_path_reg;
   logic [7:0] amp2_trim_reg;
   logic [7:0] amp2_path_reg;
   logic [7:0] gain_reg;
   logic [1:0] amp1_sync_reg;
   logic [1:0] amp2_sync_reg;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   amp_ctl_t   amp1_reg;
   amp_ctl_t   amp2_reg;
   gain_ctl_t  gain_ctl_reg;

   // decode of one amp's trim and path registers into switch controls
   function automatic amp_ctl_t decode_amp(input logic [7:0] trim, input logic [7:0] path);
      amp_ctl_t   c;
      logic [1:0] src;
      logic       en;
      en  = path[PATH_EN_BIT];
      // pin connect overrides the internal source selection
      src = path[PATH_POS_BIT] ? SRC_NONE : path[PATH_SRC_HI:PATH_SRC_LO];         // [R8]
      c.enable            = en;
      c.pins_gpio         = !en;                                                 // [R21]
      c.out_pin_switch    = en;                                                  // [R11]
      c.comparator_switch = path[PATH_CMP_BIT];                                  // [R5]
      c.self_feedback     = path[PATH_FB_BIT];                                   // [R6]
      c.high_tap_switch   = (src == SRC_HIGH);                                   // [R7]
      c.mid_tap_switch    = (src == SRC_MID);                                    // [R7]
      c.low_tap_switch    = (src == SRC_LOW);                                    // [R7]
      c.pos_pin_connect   = en && path[PATH_POS_BIT];                            // [R9] [R21]
      c.neg_pin_connect   = en && path[PATH_NEG_BIT];                            // [R9] [R21]
      c.output_drive_en   = path[PATH_OEN_BIT];                                  // [R10]
      c.trim_code         = trim[TRIM_CODE_HI:0];                                // [R4]
      if (!CAL_PRESENT) begin
         // cancellation switches do not exist in the reduced part
         c.cal_short_switch     = 1'b0;                                          // [R20]
         c.cal_neg_input_switch = 1'b0;
         c.cal_pos_input_switch = 1'b0;
      end else if (trim[TRIM_MODE_BIT]) begin
         c.cal_short_switch     = 1'b1;                                          // [R2] [R17]
         c.cal_neg_input_switch = !trim[TRIM_REF_BIT];                           // [R3]
         c.cal_pos_input_switch = trim[TRIM_REF_BIT];                            // [R3]
      end else begin
         c.cal_short_switch     = 1'b0;                                          // [R17]
         c.cal_neg_input_switch = 1'b1;
         c.cal_pos_input_switch = 1'b1;
      end
      return c;
   endfunction

   // gain for a code: unity at zero, otherwise eight per step
   function automatic logic [5:0] gain_of(input logic [2:0] code);
      return (code == 3'h0) ? GAIN_UNITY : 6'(GAIN_STEP * {3'h0, code});         // [R16]
   endfunction

   // output level synchronisers; only the second flop (bit 1) is read downstream
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         amp1_sync_reg <= 2'h0;
         amp2_sync_reg <= 2'h0;
      end else begin
         amp1_sync_reg <= {amp1_sync_reg[0], i_amp1_out_raw};                    // [R22]
         amp2_sync_reg <= {amp2_sync_reg[0], i_amp2_out_raw};                    // [R22]
      end
   end

   // writable registers; reduced variant holds the trim bits at zero
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         amp1_trim_reg <= CAL_PRESENT ? TRIM_RST : 8'h00;                        // [R23]
         amp2_trim_reg <= CAL_PRESENT ? TRIM_RST : 8'h00;
         amp1_path_reg <= PATH_RST;                                              // [R9]
         amp2_path_reg <= PATH_RST;                                              // [R12]
         gain_reg      <= GAIN_RST;                                              // [R15]
      end else if (i_wr) begin
         unique case (i_addr)
            OFS_AMP1_TRIM: begin
               if (CAL_PRESENT) begin
                  amp1_trim_reg <= i_wdata & TRIM_WR_MASK;                       // [R1] [R23]
               end
            end
            OFS_AMP2_TRIM: begin
               if (CAL_PRESENT) begin
                  amp2_trim_reg <= i_wdata & TRIM_WR_MASK;                       // [R1] [R23]
               end
            end
            OFS_AMP1_PATH: amp1_path_reg <= i_wdata;                             // [R23]
            OFS_AMP2_PATH: amp2_path_reg <= i_wdata;                             // [R12]
            OFS_AMP2_GAIN: gain_reg      <= i_wdata & GAIN_WR_MASK;              // [R19]
            default: ;
         endcase
      end
   end

   // read mux; bit7 of the trim registers shows the synchronised level
   always_comb begin
      unique case (i_addr)
         OFS_AMP1_TRIM: rdata_next = {amp1_sync_reg[1], amp1_trim_reg[6:0]};     // [R1] [R20]
         OFS_AMP2_TRIM: rdata_next = {amp2_sync_reg[1], amp2_trim_reg[6:0]};     // [R1] [R20]
         OFS_AMP1_PATH: rdata_next = amp1_path_reg;
         OFS_AMP2_PATH: rdata_next = amp2_path_reg;
         OFS_AMP2_GAIN: rdata_next = gain_reg;                                   // [R19]
         default:       rdata_next = 8'h00;
      endcase
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= i_rd ? rdata_next : 8'h00;
      end
   end

   // switch controls are registered so the analog side sees no decode glitches
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         amp1_reg     <= decode_amp(CAL_PRESENT ? TRIM_RST : 8'h00, PATH_RST);
         amp2_reg     <= decode_amp(CAL_PRESENT ? TRIM_RST : 8'h00, PATH_RST);
         gain_ctl_reg <= '{1'b0, 1'b0, 1'b0, 3'h0, GAIN_UNITY};
      end else begin
         amp1_reg <= decode_amp(amp1_trim_reg, amp1_path_reg);
         amp2_reg <= decode_amp(amp2_trim_reg, amp2_path_reg);                   // [R12]
         gain_ctl_reg.amp1_to_amp2_neg <= gain_reg[GAIN_NEG_BIT];                // [R13]
         gain_ctl_reg.amp1_to_amp2_pos <= gain_reg[GAIN_POS_BIT];                // [R14]
         gain_ctl_reg.gain_path_enable <= gain_reg[GAIN_EN_BIT];                 // [R15]
         gain_ctl_reg.gain_code        <= gain_reg[GAIN_CODE_HI:0];              // [R16]
         gain_ctl_reg.gain_value       <= gain_of(gain_reg[GAIN_CODE_HI:0]);     // [R16]
      end
   end

   assign o_rdata = rdata_reg;
   assign o_amp1  = amp1_reg;
   assign o_amp2  = amp2_reg;
   assign o_gain  = gain_ctl_reg;

   // checks on the decode and the register port
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_sys_rst);

   out_bit_read_a: assert property ( // [R1]
      i_rd && i_addr == OFS_AMP1_TRIM |=> o_rdata[7] == $past(amp1_sync_reg[1]))
      else $error("amp1 output bit does not read back the synchronised level");

   level_sync_a: assert property ( // [R22]
      !$past(i_sys_rst, 2) && !$past(i_sys_rst) |-> amp2_sync_reg[1] == $past(i_amp2_out_raw, 2))
      else $error("amp2 level not delayed by two flops");

   path_write_a: assert property ( // [R23]
      i_wr && i_addr == OFS_AMP1_PATH |=> amp1_path_reg == $past(i_wdata))
      else $error("path register did not load written byte");

   high_tap_a: assert property ( // [R7]
      amp1_path_reg[PATH_SRC_HI:PATH_SRC_LO] == SRC_HIGH && !amp1_path_reg[PATH_POS_BIT]
      |=> o_amp1.high_tap_switch && !o_amp1.mid_tap_switch && !o_amp1.low_tap_switch)
      else $error("source code 01 did not close only the high tap");

   pin_forces_none_a: assert property ( // [R8]
      amp2_path_reg[PATH_POS_BIT]
      |=> !o_amp2.high_tap_switch && !o_amp2.mid_tap_switch && !o_amp2.low_tap_switch)
      else $error("tap switch closed while pos pin connect set");

   disable_gpio_a: assert property ( // [R11]
      !amp1_path_reg[PATH_EN_BIT] |=> !o_amp1.out_pin_switch && o_amp1.pins_gpio && !o_amp1.pos_pin_connect)
      else $error("disabled amp still holds its pins");

   cancel_switches_a: assert property ( // [R17]
      CAL_PRESENT && amp1_trim_reg[TRIM_MODE_BIT]
      |=> o_amp1.cal_short_switch && (o_amp1.cal_pos_input_switch == $past(amp1_trim_reg[TRIM_REF_BIT]))
          && (o_amp1.cal_neg_input_switch != o_amp1.cal_pos_input_switch))
      else $error("cancellation mode switch pattern wrong");

   gain_reserved_a: assert property ( // [R19]
      i_rd && i_addr == OFS_AMP2_GAIN |=> o_rdata[5:4] == 2'h0)
      else $error("unimplemented gain bits read nonzero");

   gain_value_a: assert property ( // [R16]
      gain_reg[2:0] == 3'h7 |=> o_gain.gain_value == 6'h38)
      else $error("gain code 111 does not give 56");

   // read-only output bit, level path and trim loading
   amp1_out_ro_a: assert property ( // [R1]
      i_wr && i_addr == OFS_AMP1_TRIM |=> !amp1_trim_reg[TRIM_OUT_BIT])
      else $error("amp1 output bit took a write");

   amp2_out_read_a: assert property ( // [R1]
      i_rd && i_addr == OFS_AMP2_TRIM |=> o_rdata[7] == $past(amp2_sync_reg[1]))
      else $error("amp2 output bit does not read back the synchronised level");

   amp1_level_sync_a: assert property ( // [R22]
      !$past(i_sys_rst, 2) && !$past(i_sys_rst) |-> amp1_sync_reg[1] == $past(i_amp1_out_raw, 2))
      else $error("amp1 level not delayed by two flops");

   mode_write_a: assert property ( // [R2]
      CAL_PRESENT && i_wr && i_addr == OFS_AMP2_TRIM
      |=> amp2_trim_reg[TRIM_MODE_BIT] == $past(i_wdata[TRIM_MODE_BIT]))
      else $error("mode bit did not load the written value");

   trim_load_a: assert property ( // [R4] [R23]
      CAL_PRESENT && i_wr && i_addr == OFS_AMP1_TRIM |=> amp1_trim_reg[6:0] == $past(i_wdata[6:0]))
      else $error("trim register low bits did not load");

   // power-on values on the first cycle out of reset
   trim_reset_a: assert property ( // [R4] [R23]
      $fell(i_sys_rst) |-> amp1_trim_reg == (CAL_PRESENT ? TRIM_RST : 8'h00)
                           && amp2_trim_reg == (CAL_PRESENT ? TRIM_RST : 8'h00))
      else $error("trim registers not at power-on value");

   path_reset_a: assert property ( // [R9] [R23]
      $fell(i_sys_rst) |-> amp1_path_reg == PATH_RST && amp2_path_reg == PATH_RST && gain_reg == GAIN_RST)
      else $error("path or gain register not at power-on value");

   ctl_reset_a: assert property ( // [R10] [R21]
      $fell(i_sys_rst) |-> !o_amp1.output_drive_en && o_amp1.pins_gpio && !o_amp2.output_drive_en
                           && o_amp2.pins_gpio && o_gain.gain_value == GAIN_UNITY && o_rdata == 8'h00)
      else $error("switch controls not at power-on decode");

   // cancellation pattern of amp2, normal mode of amp1, reduced variant
   amp2_ref_neg_a: assert property ( // [R3] [R17]
      CAL_PRESENT && amp2_trim_reg[TRIM_MODE_BIT] && !amp2_trim_reg[TRIM_REF_BIT]
      |=> o_amp2.cal_short_switch && o_amp2.cal_neg_input_switch && !o_amp2.cal_pos_input_switch)
      else $error("amp2 reference 0 did not pick the inverting input");

   amp2_ref_pos_a: assert property ( // [R3] [R17]
      CAL_PRESENT && amp2_trim_reg[TRIM_MODE_BIT] && amp2_trim_reg[TRIM_REF_BIT]
      |=> o_amp2.cal_short_switch && o_amp2.cal_pos_input_switch && !o_amp2.cal_neg_input_switch)
      else $error("amp2 reference 1 did not pick the non-inverting input");

   normal_inputs_a: assert property ( // [R2] [R17]
      CAL_PRESENT && !amp1_trim_reg[TRIM_MODE_BIT]
      |=> o_amp1.cal_neg_input_switch && o_amp1.cal_pos_input_switch && !o_amp1.cal_short_switch)
      else $error("normal mode did not close both inputs");

   reduced_cal_off_a: assert property ( // [R20]
      !CAL_PRESENT |-> !o_amp1.cal_short_switch && !o_amp1.cal_neg_input_switch
                       && !o_amp1.cal_pos_input_switch && o_amp1.trim_code == 5'h00)
      else $error("reduced variant drives a cancellation switch");

   reduced_read_zero_a: assert property ( // [R20]
      !CAL_PRESENT && i_rd && (i_addr == OFS_AMP1_TRIM || i_addr == OFS_AMP2_TRIM)
      |=> o_rdata[6:0] == 7'h00)
      else $error("reduced variant trim bits read nonzero");

   // routing, feedback and drive bits
   amp1_cmp_route_a: assert property ( // [R5]
      1'b1 |=> o_amp1.comparator_switch == $past(amp1_path_reg[PATH_CMP_BIT]))
      else $error("amp1 comparator routing does not follow its bit");

   amp1_feedback_a: assert property ( // [R6]
      1'b1 |=> o_amp1.self_feedback == $past(amp1_path_reg[PATH_FB_BIT]))
      else $error("amp1 feedback path does not follow its bit");

   amp2_drive_en_a: assert property ( // [R10] [R12]
      1'b1 |=> o_amp2.output_drive_en == $past(amp2_path_reg[PATH_OEN_BIT]))
      else $error("amp2 output driver does not follow its bit");

   // internal source decode
   amp2_mid_tap_a: assert property ( // [R7] [R12]
      amp2_path_reg[PATH_SRC_HI:PATH_SRC_LO] == SRC_MID && !amp2_path_reg[PATH_POS_BIT]
      |=> o_amp2.mid_tap_switch && !o_amp2.high_tap_switch && !o_amp2.low_tap_switch)
      else $error("source code 10 did not close only the mid tap");

   amp1_low_tap_a: assert property ( // [R7]
      amp1_path_reg[PATH_SRC_HI:PATH_SRC_LO] == SRC_LOW && !amp1_path_reg[PATH_POS_BIT]
      |=> o_amp1.low_tap_switch && !o_amp1.high_tap_switch && !o_amp1.mid_tap_switch)
      else $error("source code 11 did not close only the low tap");

   amp1_pin_none_a: assert property ( // [R8]
      amp1_path_reg[PATH_POS_BIT]
      |=> !o_amp1.high_tap_switch && !o_amp1.mid_tap_switch && !o_amp1.low_tap_switch)
      else $error("amp1 tap switch closed while pos pin connect set");

   // pin connects are gated by the enable bit
   amp1_pins_follow_a: assert property ( // [R9] [R21]
      amp1_path_reg[PATH_EN_BIT]
      |=> o_amp1.pos_pin_connect == $past(amp1_path_reg[PATH_POS_BIT])
          && o_amp1.neg_pin_connect == $past(amp1_path_reg[PATH_NEG_BIT]))
      else $error("amp1 pin connects do not follow their bits");

   amp2_pins_follow_a: assert property ( // [R9] [R12]
      amp2_path_reg[PATH_EN_BIT]
      |=> o_amp2.pos_pin_connect == $past(amp2_path_reg[PATH_POS_BIT])
          && o_amp2.neg_pin_connect == $past(amp2_path_reg[PATH_NEG_BIT]))
      else $error("amp2 pin connects do not follow their bits");

   amp2_disable_a: assert property ( // [R11] [R21]
      !amp2_path_reg[PATH_EN_BIT]
      |=> !o_amp2.out_pin_switch && o_amp2.pins_gpio && !o_amp2.pos_pin_connect && !o_amp2.neg_pin_connect)
      else $error("disabled amp2 still holds its pins");

   // crosslink and gain controls
   neg_link_a: assert property ( // [R13]
      1'b1 |=> o_gain.amp1_to_amp2_neg == $past(gain_reg[GAIN_NEG_BIT]))
      else $error("inverting crosslink does not follow its bit");

   pos_link_a: assert property ( // [R14]
      1'b1 |=> o_gain.amp1_to_amp2_pos == $past(gain_reg[GAIN_POS_BIT]))
      else $error("non-inverting crosslink does not follow its bit");

   gain_enable_a: assert property ( // [R15]
      1'b1 |=> o_gain.gain_path_enable == $past(gain_reg[GAIN_EN_BIT]))
      else $error("gain path enable does not follow its bit");

   gain_unity_a: assert property ( // [R16]
      gain_reg[GAIN_CODE_HI:0] == 3'h0 |=> o_gain.gain_value == 6'h01)
      else $error("gain code 000 does not give unity");

   gain_mask_a: assert property ( // [R19]
      i_wr && i_addr == OFS_AMP2_GAIN |=> gain_reg[5:4] == 2'h0)
      else $error("unimplemented gain bits took a write");

endmodule
`default_nettype wire

// *** verilog/amp_switch_pkg.sv ***
// amp_switch_pkg: register map, field positions, reset values and the
// control bundles shared by the op-amp switch control block.
// assumes an 8-bit register port and one 50 MHz system clock.
`default_nettype none
package amp_switch_pkg;

   // register offsets (one byte-wide register per address)
   localparam logic [7:0] OFS_AMP1_TRIM  = 8'h00;
   localparam logic [7:0] OFS_AMP1_PATH  = 8'h01;
   localparam logic [7:0] OFS_AMP2_TRIM  = 8'h02;
   localparam logic [7:0] OFS_AMP2_PATH  = 8'h03;
   localparam logic [7:0] OFS_AMP2_GAIN  = 8'h04;

   // trim/mode register fields
   localparam int TRIM_OUT_BIT  = 7;
   localparam int TRIM_MODE_BIT = 6;
   localparam int TRIM_REF_BIT  = 5;
   localparam int TRIM_CODE_HI  = 4;

   // path control register fields
   localparam int PATH_CMP_BIT  = 7;
   localparam int PATH_FB_BIT   = 6;
   localparam int PATH_SRC_HI   = 5;
   localparam int PATH_SRC_LO   = 4;
   localparam int PATH_POS_BIT  = 3;
   localparam int PATH_NEG_BIT  = 2;
   localparam int PATH_OEN_BIT  = 1;
   localparam int PATH_EN_BIT   = 0;

   // gain/crosslink register fields
   localparam int GAIN_NEG_BIT  = 7;
   localparam int GAIN_POS_BIT  = 6;
   localparam int GAIN_EN_BIT   = 3;
   localparam int GAIN_CODE_HI  = 2;

   // writable masks and power-on values
   localparam logic [7:0] TRIM_WR_MASK  = 8'h7F;
   localparam logic [7:0] GAIN_WR_MASK  = 8'hCF;
   localparam logic [7:0] TRIM_RST      = 8'h10;
   localparam logic [7:0] PATH_RST      = 8'h0C;
   localparam logic [7:0] GAIN_RST      = 8'h00;

   // internal source codes
   localparam logic [1:0] SRC_NONE = 2'h0;
   localparam logic [1:0] SRC_HIGH = 2'h1;
   localparam logic [1:0] SRC_MID  = 2'h2;
   localparam logic [1:0] SRC_LOW  = 2'h3;

   // gain step per code and value of code zero
   localparam logic [5:0] GAIN_STEP  = 6'h08;
   localparam logic [5:0] GAIN_UNITY = 6'h01;

   // switch and path controls of one amplifier
   typedef struct packed {
      logic       cal_neg_input_switch;
      logic       cal_pos_input_switch;
      logic       cal_short_switch;
      logic [4:0] trim_code;
      logic       out_pin_switch;
      logic       comparator_switch;
      logic       low_tap_switch;
      logic       mid_tap_switch;
      logic       high_tap_switch;
      logic       self_feedback;
      logic       pos_pin_connect;
      logic       neg_pin_connect;
      logic       output_drive_en;
      logic       enable;
      logic       pins_gpio;
   } amp_ctl_t;

   // second-amplifier extras
   typedef struct packed {
      logic       amp1_to_amp2_neg;
      logic       amp1_to_amp2_pos;
      logic       gain_path_enable;
      logic [2:0] gain_code;
      logic [5:0] gain_value;
   } gain_ctl_t;

endpackage
`default_nettype wire
